// *** rtl/edc_pkg.sv ***
package edc_pkg;
  // mode word layout
  localparam int MODE_SEL_LSB   = 0;
  localparam int MODE_SEL_W     = 3;
  localparam int MODE_CLEAR_BIT = 3;
  localparam int MODE_FIFO_BIT  = 4;
  localparam int MODE_PSEL_BIT  = 5;
  localparam int MODE_NOOP_BIT  = 6;
  localparam int MODE_WORD_W    = 16;
  localparam logic [15:0] MODE_WORD_RESET = 16'h0003;

  // diagnostic layout on the system data bus
  localparam int DIAG_CB_LSB    = 8;
  localparam int DIAG_SYN1_LSB  = 16;
  localparam int DIAG_CNT_LSB   = 24;
  localparam int DIAG_TYPE_LSB  = 28;
  localparam int DIAG_SYNL_LSB  = 30;
  localparam logic [3:0] TALLY_MAX = 4'hF;

  // checkbits that accompany all-zero data
  localparam logic [7:0] ZERO_DATA_CHECKBITS = 8'h0C;

  // error type codes
  localparam logic [1:0] KIND_NONE   = 2'h0;
  localparam logic [1:0] KIND_SINGLE = 2'h1;
  localparam logic [1:0] KIND_MULTI  = 2'h2;

  typedef enum logic [2:0] {
    EDC_MODE_ERRDATA = 3'h0,
    EDC_MODE_DIAG    = 3'h1,
    EDC_MODE_DETECT  = 3'h2,
    EDC_MODE_NORMAL  = 3'h3,
    EDC_MODE_INJECT  = 3'h4
  } edc_mode_type;

  // per-byte parity, odd when odd_sel is set
  function automatic logic [7:0] edc_byte_parity(input logic [63:0] d,
                                                  input logic odd_sel);
    logic [7:0] p;
    p = 8'h00;
    for (int i = 0; i < 8; i++) begin
      p[i] = (^d[i*8 +: 8]) ^ odd_sel;
    end
    return p;
  endfunction
endpackage

// *** rtl/edc_checkgen.sv ***
module edc_checkgen
  import edc_pkg::*;
(
  // data in
  input  wire logic [63:0] data_i,
  // generated checkbits
  output logic      [7:0]  check_o
);
  // modified hamming style generator: checkbit c covers the data bits
  // whose position plus one has bit c mod 7 set; bits 2 and 3 inverted so zero data gives 0C
  always_comb begin
    check_o = ZERO_DATA_CHECKBITS;
    for (int b = 0; b < 64; b++) begin
      for (int c = 0; c < 8; c++) begin
        if ((((b + 1) >> (c % 7)) & 1) == 1 && !(c == 7 && b[0]))
          check_o[c] = check_o[c] ^ data_i[b];
      end
    end
  end
endmodule

// *** rtl/edc_errdata_mem.sv ***
module edc_errdata_mem
  import edc_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        reset_i,
  // write side
  input  wire logic        clear_i,
  input  wire logic        load_i,
  input  wire logic [63:0] data_i,
  // registered read data
  output logic      [63:0] data_o
);
  always_ff @(posedge clk_sys_i) begin
    // a load in the clear cycle wins, so that error is not lost
    if (reset_i)
      data_o <= 64'h0;
    else if (load_i)
      data_o <= data_i;
    else if (clear_i)
      data_o <= 64'h0;
  end
endmodule

// *** rtl/edc_mode_diag.sv ***
// How it works
// - mode 0 drives the stored error data word onto the system bus.
// - mode 1 drives checkbit latch and diagnostic registers onto the bus.
// - mode 2 generates checkbits on writes, detects only on reads.
// - mode 3 generates checkbits and corrects single-bit read errors.
// - mode 4 loads memory checkbit latch from system data bits 7:0.
// - injected checkbit mismatch pulls error and multiple-error flags low.
// - clear bit 1 wipes every diagnostic register; 0 does nothing.
// - after clear, mode 0 sources zero data with checkbits 0C when fifo is unselected and all lanes are enabled.
// - six diagnostic registers load on capture clock edges.
// - first-error registers load only on the first error after clear.
// - latest syndrome and 4-bit tally update every error, max 15.
// - error data readable only mode 0; the rest only mode 1.
// - mode 1 field placement on system data bits 8 to 37.
// - memory read drives per-byte parity on the parity bus.
// - memory write parity mismatch raises the parity error flag.
// - partial writes check parity only on system-supplied bytes.
// - syndrome is generated checkbits xor memory checkbits.
module edc_mode_diag
  import edc_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        reset_i,
  // mode word write
  input  wire logic        mode_write_enable_n_i,
  // system side
  input  wire logic [63:0] system_data_bus_i,
  input  wire logic [7:0]  byte_lane_enables_i,
  input  wire logic        write_fifo_select_i,
  input  wire logic        sys_write_i,
  input  wire logic [7:0]  parity_bus_i,
  output logic      [63:0] system_data_bus_o,
  output logic             system_data_oe_n_o,
  output logic      [7:0]  parity_bus_o,
  output logic             parity_error_flag_o,
  // memory side
  input  wire logic        mem_read_i,
  input  wire logic [63:0] memory_data_bus_i,
  input  wire logic [7:0]  checkbit_input_latch_i,
  output logic      [63:0] memory_data_bus_o,
  output logic      [7:0]  mem_checkbits_o,
  // error reporting
  input  wire logic        diagnostic_capture_clock_i,
  output logic             error_flag_n_o,
  output logic             multiple_error_flag_n_o,
  // mode word fields
  output logic      [2:0]  operating_mode_select_o,
  output logic             fifo_arrangement_o,
  output logic             parity_odd_o,
  output logic             noop_mode_field_o
);
  import edc_pkg::*;

  logic [15:0] edc_mode_word;
  logic        clear_pulse;
  logic [7:0]  first_error_checkbits;
  logic [7:0]  first_error_syndrome;
  logic [3:0]  error_tally;
  logic [1:0]  first_error_kind;
  logic [7:0]  latest_error_syndrome;
  logic [63:0] errored_data_word;
  logic        first_seen;
  logic        cap_q;
  logic        cap_edge;
  logic [7:0]  injected_cb;
  logic [7:0]  gen_mem_cb;
  logic [7:0]  gen_wr_cb;
  logic [7:0]  mem_cb_used;
  logic [7:0]  syndrome;
  logic        err_any;
  logic        err_single;
  logic        err_multi;
  logic        col_hit;
  logic        log_event;
  logic        first_load;
  logic [63:0] read_word;
  logic [7:0]  gen_err_cb;
  logic [63:0] corrected;
  logic [63:0] merged;
  logic [7:0]  sys_par;
  edc_mode_type mode;

  assign mode = edc_mode_type'(edc_mode_word[MODE_SEL_LSB +: MODE_SEL_W]);
  assign operating_mode_select_o = edc_mode_word[MODE_SEL_LSB +: MODE_SEL_W];
  assign fifo_arrangement_o = edc_mode_word[MODE_FIFO_BIT];
  assign parity_odd_o       = edc_mode_word[MODE_PSEL_BIT];
  assign noop_mode_field_o  = edc_mode_word[MODE_NOOP_BIT];

  // mode word capture; clear is a self-clearing action, not stored
  always_ff @(posedge clk_sys_i) begin
    if (reset_i)
      edc_mode_word <= MODE_WORD_RESET;
    else if (!mode_write_enable_n_i)
      edc_mode_word <= system_data_bus_i[15:0] &
                       ~(16'h0001 << MODE_CLEAR_BIT);
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i)
      clear_pulse <= 1'b0;
    else
      clear_pulse <= !mode_write_enable_n_i &&
                     system_data_bus_i[MODE_CLEAR_BIT];
  end

  // capture clock is sampled as a synchronous input
  always_ff @(posedge clk_sys_i) begin
    if (reset_i)
      cap_q <= 1'b0;
    else
      cap_q <= diagnostic_capture_clock_i;
  end
  assign cap_edge = diagnostic_capture_clock_i && !cap_q;

  // injection latch: system bits feed the memory checkbit latch
  always_ff @(posedge clk_sys_i) begin
    if (reset_i)
      injected_cb <= 8'h00;
    else if (mode == EDC_MODE_INJECT && sys_write_i)
      injected_cb <= system_data_bus_i[7:0];
  end

  edc_checkgen u_gen_mem (
    .data_i  (memory_data_bus_i),
    .check_o (gen_mem_cb)
  );

  // write merge: enabled lanes from system, others from memory
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      merged[i*8 +: 8] = byte_lane_enables_i[i] ?
                         system_data_bus_i[i*8 +: 8] :
                         memory_data_bus_i[i*8 +: 8];
    end
  end

  edc_checkgen u_gen_wr (
    .data_i  (merged),
    .check_o (gen_wr_cb)
  );

  assign mem_cb_used = (mode == EDC_MODE_INJECT) ? injected_cb
                                                  : checkbit_input_latch_i;
  assign syndrome    = gen_mem_cb ^ mem_cb_used;
  assign err_any     = mem_read_i && (syndrome != 8'h00);
  // a data-column match is a single error as well as a lone checkbit
  assign err_single  = err_any && ($onehot(syndrome) || col_hit);
  assign err_multi   = err_any && !err_single;
  assign log_event   = cap_edge && err_any;
  // a capture in the clear cycle wins and starts a fresh log
  assign first_load  = log_event && (!first_seen || clear_pulse);
  // detect-only modes hand the raw word on, normal mode the fixed one
  assign read_word   = (mode == EDC_MODE_NORMAL) ? corrected
                                                 : memory_data_bus_i;

  // single-bit correction by matching the syndrome of each data bit
  always_comb begin
    logic [63:0] unit;
    logic [7:0]  s1;
    unit      = 64'h0;
    s1        = 8'h00;
    corrected = memory_data_bus_i;
    col_hit   = 1'b0;
    for (int b = 0; b < 64; b++) begin
      unit = 64'h1 << b;
      s1 = 8'h00;
      for (int c = 0; c < 8; c++) begin
        if ((((b + 1) >> (c % 7)) & 1) == 1 && !(c == 7 && b[0]))
          s1[c] = 1'b1;
      end
      if (err_any && s1 == syndrome) begin
        corrected = memory_data_bus_i ^ unit;
        col_hit   = 1'b1;
      end
    end
  end

  // first-error registers
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      first_seen            <= 1'b0;
      first_error_checkbits <= 8'h00;
      first_error_syndrome  <= 8'h00;
      first_error_kind      <= KIND_NONE;
    end else if (first_load) begin
      first_seen            <= 1'b1;
      first_error_checkbits <= mem_cb_used;
      first_error_syndrome  <= syndrome;
      first_error_kind      <= err_single ? KIND_SINGLE : KIND_MULTI;
    end else if (clear_pulse) begin
      first_seen            <= 1'b0;
      first_error_checkbits <= 8'h00;
      first_error_syndrome  <= 8'h00;
      first_error_kind      <= KIND_NONE;
    end
  end

  // every-error registers; tally saturates at 15
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      error_tally           <= 4'h0;
      latest_error_syndrome <= 8'h00;
    end else if (log_event) begin
      latest_error_syndrome <= syndrome;
      if (clear_pulse)
        error_tally <= 4'h1;
      else if (error_tally != TALLY_MAX)
        error_tally <= error_tally + 4'h1;
    end else if (clear_pulse) begin
      error_tally           <= 4'h0;
      latest_error_syndrome <= 8'h00;
    end
  end

  // error data word held in its own storage module
  edc_errdata_mem u_errdata (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .clear_i   (clear_pulse),
    .load_i    (first_load),
    .data_i    (memory_data_bus_i),
    .data_o    (errored_data_word)
  );

  // checkbits of the stored word, used when it wraps to memory
  edc_checkgen u_gen_err (
    .data_i  (errored_data_word),
    .check_o (gen_err_cb)
  );

  // system bus output, registered
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      system_data_bus_o  <= 64'h0;
      system_data_oe_n_o <= 1'b1;
    end else begin
      system_data_oe_n_o <= !(mem_read_i || mode == EDC_MODE_ERRDATA ||
                              mode == EDC_MODE_DIAG);
      unique case (mode)
        EDC_MODE_ERRDATA:
          system_data_bus_o <= errored_data_word;
        EDC_MODE_DIAG: begin
          system_data_bus_o <= 64'h0;
          system_data_bus_o[7:0] <= checkbit_input_latch_i;
          system_data_bus_o[DIAG_CB_LSB +: 8] <= first_error_checkbits;
          system_data_bus_o[DIAG_SYN1_LSB +: 8] <= first_error_syndrome;
          system_data_bus_o[DIAG_CNT_LSB +: 4] <= error_tally;
          system_data_bus_o[DIAG_TYPE_LSB +: 2] <= first_error_kind;
          system_data_bus_o[DIAG_SYNL_LSB +: 8] <= latest_error_syndrome;
        end
        EDC_MODE_NORMAL:
          system_data_bus_o <= corrected;
        EDC_MODE_DETECT, EDC_MODE_INJECT:
          system_data_bus_o <= memory_data_bus_i;
        default:
          system_data_bus_o <= memory_data_bus_i;
      endcase
    end
  end

  // memory side write data and checkbits; in mode 0 with fifo unselected and all
  // lanes enabled the cleared error word wraps back, giving zero data with checkbits 0C
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      memory_data_bus_o <= 64'h0;
      mem_checkbits_o   <= ZERO_DATA_CHECKBITS;
    end else if (mode == EDC_MODE_ERRDATA && !write_fifo_select_i &&
                 byte_lane_enables_i == 8'hFF) begin
      memory_data_bus_o <= errored_data_word;
      mem_checkbits_o   <= (errored_data_word == 64'h0) ?
                           ZERO_DATA_CHECKBITS : gen_err_cb;
    end else begin
      memory_data_bus_o <= merged;
      mem_checkbits_o   <= (mode == EDC_MODE_INJECT) ? injected_cb
                                                     : gen_wr_cb;
    end
  end

  // flags, parity out and parity check
  always_comb begin
    sys_par = edc_byte_parity(system_data_bus_i, parity_odd_o);
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      error_flag_n_o          <= 1'b1;
      multiple_error_flag_n_o <= 1'b1;
      parity_bus_o            <= 8'h00;
      parity_error_flag_o     <= 1'b0;
    end else begin
      error_flag_n_o          <= !err_any;
      multiple_error_flag_n_o <= !(err_multi ||
                                   (mode == EDC_MODE_INJECT && err_any));
      if (mem_read_i)
        parity_bus_o <= edc_byte_parity(read_word, parity_odd_o);
      // only system-supplied lanes are compared
      parity_error_flag_o <= sys_write_i &&
        (((sys_par ^ parity_bus_i) & byte_lane_enables_i) != 8'h00);
    end
  end

  // assertions
  a_tally_saturates: assert property (@(posedge clk_sys_i)
    disable iff (reset_i)
    error_tally == TALLY_MAX && !clear_pulse |=> error_tally == TALLY_MAX)
    else $error("error tally wrapped");

  a_first_held: assert property (@(posedge clk_sys_i)
    disable iff (reset_i)
    first_seen && !clear_pulse |=> $stable(first_error_syndrome))
    else $error("first syndrome changed");

  a_clear_wipes: assert property (@(posedge clk_sys_i)
    disable iff (reset_i)
    clear_pulse && !log_event |=>
      error_tally == 4'h0 && errored_data_word == 64'h0)
    else $error("clear missed a register");

  a_inject_flag: assert property (@(posedge clk_sys_i)
    disable iff (reset_i)
    mode == EDC_MODE_INJECT && err_any |=> !multiple_error_flag_n_o)
    else $error("injection mismatch not flagged");

  a_mode_capture: assert property (@(posedge clk_sys_i)
    disable iff (reset_i)
    !mode_write_enable_n_i |=>
      operating_mode_select_o == $past(system_data_bus_i[2:0]))
    else $error("mode word not captured");

  // clear takes two edges: the write, then the wipe
  sequence s_clear_req;
    !mode_write_enable_n_i && system_data_bus_i[MODE_CLEAR_BIT];
  endsequence

  sequence s_quiet;
    !log_event;
  endsequence

  sequence s_wiped;
    first_error_kind == KIND_NONE && latest_error_syndrome == 8'h00 &&
    !first_seen;
  endsequence

  a_clear_sequence: assert property (@(posedge clk_sys_i)
    disable iff (reset_i)
    s_clear_req ##1 s_quiet |=> s_wiped)
    else $error("clear request left a register set");

  a_tally_step: assert property (@(posedge clk_sys_i)
    disable iff (reset_i)
    log_event && !clear_pulse && error_tally != TALLY_MAX |=>
      error_tally == $past(error_tally) + 4'h1)
    else $error("error tally missed a count");

  a_diag_drive: assert property (@(posedge clk_sys_i)
    disable iff (reset_i)
    mode == EDC_MODE_DIAG |=> !system_data_oe_n_o)
    else $error("diagnostic mode left the bus undriven");
endmodule

// *** bench/edc_mem_model.sv ***
module edc_mem_model (
  // timing
  input  wire logic        clk_sys_i,
  // read request and fault pattern
  input  wire logic        mem_read_i,
  input  wire logic [63:0] flip_i,
  // memory array outputs
  output logic      [63:0] md_o,
  output logic      [7:0]  cb_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [63:0] last_md = 64'h0;
  logic [7:0]  last_cb = 8'h0C;
  // stored word is all zero; flip_i plants faults in it
  always_ff @(posedge clk_sys_i) begin
    if (mem_read_i) begin
      last_md <= flip_i;
      last_cb <= 8'h0C;
    end
  end
  // released bus shows the inverse, never a stale copy
  assign md_o = mem_read_i ? flip_i : ~last_md;
  assign cb_o = mem_read_i ? 8'h0C : ~last_cb;
endmodule

// *** bench/tb_top.sv ***
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import edc_pkg::*;
  typedef struct {
    logic [15:0] w;
    logic        wr;
    logic        rd;
    logic [63:0] d;
    logic [7:0]  p;
    logic [7:0]  be;
    logic        en;
    logic [7:0]  po;
    logic        pe;
  } edc_row_type;
  logic        clk_sys_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        mode_write_enable_n_i = 1'b1;
  logic [63:0] system_data_bus_i = 64'h0;
  logic [7:0]  byte_lane_enables_i = 8'hFF;
  logic        write_fifo_select_i = 1'b0;
  logic        sys_write_i = 1'b0;
  logic [7:0]  parity_bus_i = 8'h00;
  logic        mem_read_i = 1'b0;
  logic [63:0] flip = 64'h0;
  logic        diagnostic_capture_clock_i = 1'b0;
  logic [63:0] memory_data_bus_i, system_data_bus_o, memory_data_bus_o;
  logic [7:0]  checkbit_input_latch_i, parity_bus_o, mem_checkbits_o;
  logic [2:0]  operating_mode_select_o;
  logic        system_data_oe_n_o, parity_error_flag_o, error_flag_n_o;
  logic        multiple_error_flag_n_o, fifo_arrangement_o;
  logic        parity_odd_o, noop_mode_field_o;
  int          n_errors = 0;
  int          n_compared = 0;
  edc_row_type rows [8];

  always #50 clk_sys_i = ~clk_sys_i;

  edc_mode_diag edc_mode_diag_i (
    .clk_sys_i                  (clk_sys_i),
    .reset_i                    (reset_i),
    .mode_write_enable_n_i      (mode_write_enable_n_i),
    .system_data_bus_i          (system_data_bus_i),
    .byte_lane_enables_i        (byte_lane_enables_i),
    .write_fifo_select_i        (write_fifo_select_i),
    .sys_write_i                (sys_write_i),
    .parity_bus_i               (parity_bus_i),
    .system_data_bus_o          (system_data_bus_o),
    .system_data_oe_n_o         (system_data_oe_n_o),
    .parity_bus_o               (parity_bus_o),
    .parity_error_flag_o        (parity_error_flag_o),
    .mem_read_i                 (mem_read_i),
    .memory_data_bus_i          (memory_data_bus_i),
    .checkbit_input_latch_i     (checkbit_input_latch_i),
    .memory_data_bus_o          (memory_data_bus_o),
    .mem_checkbits_o            (mem_checkbits_o),
    .diagnostic_capture_clock_i (diagnostic_capture_clock_i),
    .error_flag_n_o             (error_flag_n_o),
    .multiple_error_flag_n_o    (multiple_error_flag_n_o),
    .operating_mode_select_o    (operating_mode_select_o),
    .fifo_arrangement_o         (fifo_arrangement_o),
    .parity_odd_o               (parity_odd_o),
    .noop_mode_field_o          (noop_mode_field_o)
  );
  edc_mem_model edc_mem_model_i (
    .clk_sys_i  (clk_sys_i),
    .mem_read_i (mem_read_i),
    .flip_i     (flip),
    .md_o       (memory_data_bus_i),
    .cb_o       (checkbit_input_latch_i)
  );

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  task automatic chk(input string nm, input logic [63:0] seen,
                     input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr_mode(input logic [15:0] w);
    @(posedge clk_sys_i) begin
      mode_write_enable_n_i <= 1'b0;
      system_data_bus_i <= {48'h0, w};
    end
    @(posedge clk_sys_i) mode_write_enable_n_i <= 1'b1;
    step(3);
  endtask

  // one capture edge: low before, high for one sampled edge
  task automatic cap(input logic [63:0] mask);
    @(posedge clk_sys_i) begin
      mem_read_i <= 1'b1;
      flip <= mask;
      diagnostic_capture_clock_i <= 1'b1;
    end
    @(posedge clk_sys_i) begin
      mem_read_i <= 1'b0;
      diagnostic_capture_clock_i <= 1'b0;
    end
    step(1);
  endtask

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys_i);
    n_errors++;
    $display("mismatch watchdog expected done seen hang");
    tally_and_finish();
  end

  initial begin
    rows = '{
      '{16'h0003, 0, 1, 64'h0, 8'h00, 8'hFF, 1, 8'h00, 0},
      '{16'h0003, 0, 1, 64'h1, 8'h00, 8'hFF, 0, 8'h00, 0},
      '{16'h0002, 0, 1, 64'h1, 8'h00, 8'hFF, 0, 8'h01, 0},
      '{16'h0023, 0, 1, 64'h0, 8'h00, 8'hFF, 1, 8'hFF, 0},
      '{16'h0003, 1, 0, 64'h1, 8'h00, 8'hFF, 1, 8'h00, 1},
      '{16'h0003, 1, 0, 64'h1, 8'h01, 8'hFF, 1, 8'h00, 0},
      '{16'h0003, 1, 0, 64'h100, 8'h00, 8'h01, 1, 8'h00, 0},
      '{16'h0023, 1, 0, 64'h0, 8'h00, 8'hFF, 1, 8'h00, 1}};
    step(10);
    reset_i <= 1'b0;
    step(2);
    chk("mode_sel", operating_mode_select_o, 3);
    chk("fifo_odd_noop", {fifo_arrangement_o, parity_odd_o,
        noop_mode_field_o}, 0);
    chk("flags_n", {error_flag_n_o, multiple_error_flag_n_o}, 3);
    chk("mem_cb", mem_checkbits_o, ZERO_DATA_CHECKBITS);
    $display("test reset done");
    foreach (rows[i]) begin
      wr_mode(rows[i].w);
      @(posedge clk_sys_i) begin
        sys_write_i <= rows[i].wr;
        mem_read_i <= rows[i].rd;
        system_data_bus_i <= rows[i].d;
        flip <= rows[i].d;
        parity_bus_i <= rows[i].p;
        byte_lane_enables_i <= rows[i].be;
      end
      step(3);
      if (rows[i].rd) begin
        chk("err_n", error_flag_n_o, rows[i].en);
        chk("par_o", parity_bus_o, rows[i].po);
      end
      if (rows[i].wr)
        chk("parity_error_flag", parity_error_flag_o, rows[i].pe);
      @(posedge clk_sys_i) begin
        sys_write_i <= 1'b0;
        mem_read_i <= 1'b0;
        byte_lane_enables_i <= 8'hFF;
      end
    end
    $display("test table done");
    wr_mode(16'h0009);
    chk("diag_clr", system_data_bus_o[63:8], 0);
    chk("cbi", system_data_bus_o[7:0], checkbit_input_latch_i);
    chk("oe_n", system_data_oe_n_o, 0);
    wr_mode(16'h0003);
    cap(64'h20);
    cap(64'h200);
    wr_mode(16'h0001);
    chk("tally", system_data_bus_o[27:24], 2);
    chk("kind", system_data_bus_o[29:28], KIND_SINGLE);
    chk("first_cb", system_data_bus_o[15:8], 8'h0C);
    chk("syn_differ", system_data_bus_o[23:16] !==
        system_data_bus_o[37:30], 1);
    wr_mode(16'h0000);
    chk("err_word", system_data_bus_o, 64'h20);
    wr_mode(16'h0003);
    repeat (14) cap(64'h1);
    wr_mode(16'h0001);
    chk("tally_sat", system_data_bus_o[27:24], TALLY_MAX);
    $display("test logging done");
    wr_mode(16'h0008);
    chk("zero_src", system_data_bus_o, 0);
    // wrap path: all lanes enabled, fifo not selected
    @(posedge clk_sys_i) begin
      system_data_bus_i <= 64'hA5A5_5A5A_0F0F_F0F0;
      sys_write_i <= 1'b1;
    end
    step(3);
    chk("zero_md", memory_data_bus_o, 0);
    chk("zero_cb", mem_checkbits_o, ZERO_DATA_CHECKBITS);
    @(posedge clk_sys_i) write_fifo_select_i <= 1'b1;
    step(3);
    chk("fifo_md", memory_data_bus_o, 64'hA5A5_5A5A_0F0F_F0F0);
    @(posedge clk_sys_i) begin
      sys_write_i <= 1'b0;
      write_fifo_select_i <= 1'b0;
    end
    wr_mode(16'h0004);
    @(posedge clk_sys_i) begin
      system_data_bus_i <= 64'h5A;
      sys_write_i <= 1'b1;
    end
    @(posedge clk_sys_i) sys_write_i <= 1'b0;
    step(2);
    chk("inject_cb", mem_checkbits_o, 8'h5A);
    @(posedge clk_sys_i) mem_read_i <= 1'b1;
    step(3);
    chk("inject_flags", {error_flag_n_o, multiple_error_flag_n_o}, 0);
    @(posedge clk_sys_i) mem_read_i <= 1'b0;
    $display("test inject done");
    @(posedge clk_sys_i) reset_i <= 1'b1;
    step(2);
    @(posedge clk_sys_i) reset_i <= 1'b0;
    step(2);
    chk("rst_mode", operating_mode_select_o, 3);
    chk("rst_flags_n", {error_flag_n_o, multiple_error_flag_n_o}, 3);
    chk("rst_oe_n", system_data_oe_n_o, 1);
    $display("test reset again done");
    tally_and_finish();
  end
endmodule
